// ===== hw/sir_port.sv
module sir_port
(
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              resetn,
   // two-wire pins
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe,
   // sensor results and events
   input  wire sir_pkg::byte_type ambient_high,
   input  wire sir_pkg::byte_type ambient_low,
   input  wire sir_pkg::byte_type proximity_value,
   input  wire logic              ambient_event,
   input  wire logic              proximity_event,
   // status towards the sensor core
   output sir_pkg::byte_type      interrupt_flags,
   output logic                   int_n
);
   import sir_pkg::*;
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_RX   = 3'b001,
      ST_ACK  = 3'b011,
      ST_TX   = 3'b010,
      ST_MACK = 3'b110
   } sir_state_type;
   typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} sir_kind_type;

   sir_reg_if bus ();
   sir_state_type state_reg, state_next;
   sir_kind_type  kind_reg, kind_next;
   logic [2:0]    cnt_reg, cnt_next;
   byte_type      sh_reg, sh_next;
   byte_type      ptr_reg, ptr_next;
   logic          oe_next;
   logic          rw_reg, rw_next;
   logic          rep_reg, rep_next;
   logic          frame_reg, frame_next;
   logic          sth_reg, sth_next;
   logic          full_reg, full_next;
   logic          ackok_reg, ackok_next;
   logic          scl_s, sda_s, scl_q, sda_q;
   logic          scl_rise, scl_fall, start, stop;
   logic          addr_hit, byte_end, load_now, write_now;
   byte_type      ptr_inc;

   // scl is sampled like any other pin; at 25 MHz a 400 kHz half period
   // gives about 31 samples against four of latency
   sir_sync u_scl (.ref_clk(ref_clk), .resetn(resetn), .pin(scl_in), .level(scl_s));
   sir_sync u_sda (.ref_clk(ref_clk), .resetn(resetn), .pin(sda_in), .level(sda_s));

   sir_regs u_regs
   (
      .ref_clk    (ref_clk),
      .resetn     (resetn),
      .bus        (bus.regs),
      .amb_hi     (ambient_high),
      .amb_lo     (ambient_low),
      .proximity_channel_val   (proximity_value),
      .amb_event  (ambient_event),
      .proximity_channel_event (proximity_event),
      .flags_reg  (interrupt_flags),
      .int_n      (int_n)
   );

   assign scl_rise = scl_s && !scl_q;
   assign scl_fall = !scl_s && scl_q;
   assign start    = scl_s && scl_q && sda_q && !sda_s;
   assign stop     = scl_s && scl_q && !sda_q && sda_s;
   assign addr_hit = sh_reg[7:1] == DEV_ADDR;
   assign byte_end = state_reg == ST_RX && scl_fall && full_reg;
   assign ptr_inc  = (ptr_reg == ADDR_TOP) ? ptr_reg : ptr_reg + 8'h01;
   assign load_now = scl_fall && ((state_reg == ST_ACK && rw_reg)
                     || (state_reg == ST_MACK && ackok_reg));
   assign write_now = byte_end && kind_reg == K_DATA;
   assign bus.addr  = ptr_reg;
   assign bus.wdata = sh_reg;
   assign bus.wr    = write_now;
   assign bus.rd    = load_now;

   always_comb
   begin
      state_next = state_reg;
      kind_next  = kind_reg;
      cnt_next   = cnt_reg;
      sh_next    = sh_reg;
      ptr_next   = ptr_reg;
      oe_next    = sda_oe;
      rw_next    = rw_reg;
      rep_next   = rep_reg;
      frame_next = frame_reg;
      sth_next   = sth_reg && !scl_fall;
      full_next  = full_reg;
      ackok_next = ackok_reg;
      if (start)
      begin
         state_next = ST_RX;
         kind_next  = K_ADDR;
         cnt_next   = 3'h0;
         rep_next   = frame_reg;
         frame_next = 1'b1;
         sth_next   = 1'b1;
         full_next  = 1'b0;
         oe_next    = 1'b0;
      end
      else if (stop && !sth_reg)
      begin
         state_next = ST_IDLE;
         frame_next = 1'b0;
         full_next  = 1'b0;
         oe_next    = 1'b0;
      end
      else
      begin
         unique case (state_reg)
            ST_IDLE: ;
            ST_RX:
            begin
               if (scl_rise)
               begin
                  sh_next   = {sh_reg[6:0], sda_s};
                  cnt_next  = cnt_reg + 3'h1;
                  full_next = cnt_reg == LAST_BIT;
               end
               else if (byte_end)
               begin
                  full_next = 1'b0;
                  if (kind_reg == K_ADDR && !addr_hit)
                     state_next = ST_IDLE;
                  else
                  begin
                     state_next = ST_ACK;
                     oe_next    = 1'b1;
                  end
                  if (kind_reg == K_ADDR)
                  begin
                     rw_next = sh_reg[0];
                     if (sh_reg[0] && !rep_reg && addr_hit)
                        ptr_next = PTR_RESET;
                  end
                  else if (kind_reg == K_PTR)
                     ptr_next = sh_reg;
                  else
                     ptr_next = ptr_inc;
               end
            end
            ST_ACK:
            begin
               if (scl_fall)
               begin
                  cnt_next = 3'h0;
                  if (rw_reg)
                  begin
                     state_next = ST_TX;
                     sh_next    = bus.rdata;
                     ptr_next   = ptr_inc;
                     oe_next    = !bus.rdata[7];
                  end
                  else
                  begin
                     state_next = ST_RX;
                     oe_next    = 1'b0;
                     kind_next  = (kind_reg == K_ADDR) ? K_PTR : K_DATA;
                  end
               end
            end
            ST_TX:
            begin
               if (scl_fall)
               begin
                  cnt_next = cnt_reg + 3'h1;
                  if (cnt_reg == LAST_BIT)
                  begin
                     state_next = ST_MACK;
                     oe_next    = 1'b0;
                  end
                  else
                  begin
                     sh_next = {sh_reg[6:0], 1'b0};
                     oe_next = !sh_reg[6];
                  end
               end
            end
            ST_MACK:
            begin
               if (scl_rise)
                  ackok_next = !sda_s;
               else if (scl_fall)
               begin
                  cnt_next = 3'h0;
                  if (ackok_reg)
                  begin
                     state_next = ST_TX;
                     sh_next    = bus.rdata;
                     ptr_next   = ptr_inc;
                     oe_next    = !bus.rdata[7];
                  end
                  else
                     state_next = ST_IDLE;
               end
            end
            default: state_next = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= ST_IDLE;
         kind_reg  <= K_ADDR;
         cnt_reg   <= 3'h0;
         sh_reg    <= ZERO_BYTE;
         ptr_reg   <= PTR_RESET;
         sda_oe    <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         kind_reg  <= kind_next;
         cnt_reg   <= cnt_next;
         sh_reg    <= sh_next;
         ptr_reg   <= ptr_next;
         sda_oe    <= oe_next;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rw_reg    <= 1'b0;
         rep_reg   <= 1'b0;
         frame_reg <= 1'b0;
         sth_reg   <= 1'b0;
         full_reg  <= 1'b0;
         ackok_reg <= 1'b0;
         sda_out   <= 1'b0;
      end
      else
      begin
         rw_reg    <= rw_next;
         rep_reg   <= rep_next;
         frame_reg <= frame_next;
         sth_reg   <= sth_next;
         full_reg  <= full_next;
         ackok_reg <= ackok_next;
         sda_out   <= 1'b0;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   bit_count_a: assert property (state_reg == ST_RX && scl_rise
      |=> cnt_reg == $past(cnt_reg) + 3'h1)
      else $error("sampled clock rise not counted");
   addr_miss_a: assert property (byte_end && kind_reg == K_ADDR && !addr_hit
      |=> state_reg == ST_IDLE && !sda_oe)
      else $error("foreign address acknowledged");
   ack_hold_a: assert property (byte_end && (kind_reg != K_ADDR || addr_hit)
      |=> sda_oe throughout (state_reg == ST_ACK)[*3])
      else $error("ack not held low");
   start_frame_a: assert property (start |=> state_reg == ST_RX && cnt_reg == 3'h0)
      else $error("start did not open a byte");
   stop_abandon_a: assert property (stop && !sth_reg |=> state_reg == ST_IDLE && !sda_oe)
      else $error("stop did not end the frame");
   ptr_zero_a: assert property (byte_end && kind_reg == K_ADDR && addr_hit
      && sh_reg[0] && !rep_reg |=> ptr_reg == PTR_RESET)
      else $error("pointer not reset for plain read");
   ptr_step_a: assert property (load_now && ptr_reg != ADDR_TOP
      |=> ptr_reg == $past(ptr_reg) + 8'h01)
      else $error("pointer did not step after read");
   ptr_top_a: assert property (load_now && ptr_reg == ADDR_TOP |=> ptr_reg == ADDR_TOP)
      else $error("pointer left top register");
   wr_step_a: assert property (write_now && ptr_reg != ADDR_TOP
      |=> ptr_reg == $past(ptr_reg) + 8'h01)
      else $error("pointer did not step after write");
   tx_stable_a: assert property (state_reg == ST_TX && scl_s && scl_q |=> $stable(sda_oe))
      else $error("data moved while clock high");
   byte_len_a: assert property (state_reg == ST_TX && scl_fall && cnt_reg == LAST_BIT
      |=> state_reg == ST_MACK && !sda_oe)
      else $error("read byte not eight bits");
   cover property (write_now);
   cover property (load_now && rep_reg);
   cover property (state_reg == ST_MACK && scl_fall && !ackok_reg);
   cover property (stop && sth_reg);
endmodule // sir_port

// ===== common/sir_pkg.sv
package sir_pkg;
   typedef logic [7:0] byte_type;
   // bus address and framing
   localparam logic [6:0] DEV_ADDR   = 7'h4a;
   localparam int         BYTE_BITS  = 8;
   localparam logic [2:0] LAST_BIT   = 3'h7;
   // register map
   localparam byte_type ADDR_FLAGS   = 8'h00;
   localparam byte_type ADDR_MAIN    = 8'h01;
   localparam byte_type ADDR_RXCFG   = 8'h02;
   localparam byte_type ADDR_TXCFG   = 8'h03;
   localparam byte_type ADDR_AMB_HI  = 8'h04;
   localparam byte_type ADDR_AMB_LO  = 8'h05;
   localparam byte_type ADDR_PERSIST = 8'h0a;
   localparam byte_type ADDR_PROXIMITY_CHANNEL    = 8'h15;
   localparam byte_type ADDR_RSVD    = 8'hf6;
   localparam byte_type ADDR_TOP     = 8'hff;
   localparam byte_type PTR_RESET    = 8'h00;
   // flag and enable fields
   localparam int       FLAG_AMB     = 0;
   localparam int       FLAG_PROXIMITY_CHANNEL    = 1;
   localparam int       FLAG_PON     = 2;
   localparam byte_type FLAG_EN_MASK = 8'h03;
   localparam byte_type FLAGS_RESET  = 8'h04;
   localparam byte_type CFG_RESET    = 8'h00;
   localparam byte_type ZERO_BYTE    = 8'h00;
   // timing
   localparam int CLK_HZ       = 25_000_000;
   localparam int SCL_MAX_HZ   = 400_000;
   localparam int SCL_HALF_CYC = CLK_HZ / (2 * SCL_MAX_HZ);
   localparam int SYNC_LAT     = 4;
endpackage

// ===== common/sir_reg_if.sv
interface sir_reg_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       wr;
   logic       rd;
   modport link (output addr, output wdata, output wr, output rd, input rdata);
   modport regs (input addr, input wdata, input wr, input rd, output rdata);
endinterface

// ===== hw/sir_sync.sv
module sir_sync
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic resetn,
   // pin and clean level
   input  wire logic pin,
   output logic      level
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   // idle bus level is high, so reset to one
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
         level  <= 1'b1;
      end
      else
      begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg)
            level <= s3_reg;
      end
   end
endmodule // sir_sync

// ===== hw/sir_regs.sv
module sir_regs
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // access from the link side
   sir_reg_if.regs          bus,
   // sensor side
   input  wire logic [7:0]  amb_hi,
   input  wire logic [7:0]  amb_lo,
   input  wire logic [7:0]  proximity_channel_val,
   input  wire logic        amb_event,
   input  wire logic        proximity_channel_event,
   output logic [7:0]       flags_reg,
   output logic             int_n
);
   import sir_pkg::*;
   byte_type mem [0:255];
   byte_type set_mask;
   byte_type clr_mask;
   byte_type flags_next;
   logic     clr_rd;
   logic     clr_dis;
   logic     wr_ok;
   logic     int_next;
   assign clr_rd   = bus.rd && bus.addr == ADDR_FLAGS;
   assign clr_dis  = bus.wr && bus.addr == ADDR_MAIN;
   assign clr_mask = clr_rd ? 8'hff : (clr_dis ? (FLAG_EN_MASK & ~bus.wdata) : ZERO_BYTE);
   assign set_mask = {6'h00, proximity_channel_event, amb_event};
   // set wins over clear so an event in the clearing cycle survives
   assign flags_next = (flags_reg & ~clr_mask) | set_mask;
   // power-on flag sits outside the enable mask and never pulls the pin
   assign int_next = ~|(flags_reg & mem[ADDR_MAIN] & FLAG_EN_MASK);
   assign wr_ok = bus.wr && bus.addr != ADDR_FLAGS && bus.addr != ADDR_AMB_HI
                  && bus.addr != ADDR_AMB_LO && bus.addr != ADDR_PROXIMITY_CHANNEL && bus.addr < ADDR_RSVD;
   assign bus.rdata = (bus.addr == ADDR_FLAGS)  ? flags_reg :
                      (bus.addr == ADDR_AMB_HI) ? amb_hi :
                      (bus.addr == ADDR_AMB_LO) ? amb_lo :
                      (bus.addr == ADDR_PROXIMITY_CHANNEL)   ? proximity_channel_val :
                      (bus.addr >= ADDR_RSVD)   ? ZERO_BYTE : mem[bus.addr];
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         flags_reg <= FLAGS_RESET;
         int_n     <= 1'b1;
      end
      else
      begin
         flags_reg <= flags_next;
         int_n     <= int_next;
      end
   end
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < 256; i++)
            mem[i] <= CFG_RESET;
      end
      else if (wr_ok)
         mem[bus.addr] <= bus.wdata;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   pon_quiet_a: assert property (!int_n |-> |$past(flags_reg & mem[ADDR_MAIN] & FLAG_EN_MASK))
      else $error("interrupt pin low without an enabled flag");
   read_clear_a: assert property (clr_rd && !amb_event && !proximity_channel_event |=> flags_reg == ZERO_BYTE)
      else $error("status read did not clear flags");
   cover property (clr_rd && flags_reg[FLAG_PON]);
endmodule // sir_regs

// ===== verif/sir_master.sv
module sir_master
(
   // clock
   input  wire logic ref_clk,
   // bus lines
   output logic      scl,
   output logic      sda_m,
   input  wire logic sda_wire
);
   timeunit 1ns;
   timeprecision 1ps;

   // 240 ns low, 80 ns high: the 320 ns link period
   // long low phase so a read bit settles before the rise, not with it
   localparam int LOW_CYC  = 6;
   localparam int HIGH_CYC = 2;

   initial
   begin
      scl   = 1'b1;
      sda_m = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // data moves only mid-low, never while the clock is high
   // sampled late in the high phase: the device's sync latency eats most of the low phase
   task automatic clock_bit(input logic b, output logic got);
      tick(2);
      sda_m <= b;
      tick(LOW_CYC - 2);
      scl <= 1'b1;
      tick(HIGH_CYC);
      got = sda_wire;
      scl <= 1'b0;
   endtask

   // start or repeated start: data falls while clock high
   task automatic start();
      tick(2);
      sda_m <= 1'b1;
      tick(LOW_CYC - 2);
      scl <= 1'b1;
      tick(HIGH_CYC);
      sda_m <= 1'b0;
      tick(HIGH_CYC);
      scl <= 1'b0;
   endtask

   // stop always in a later high pulse than the start
   task automatic stop();
      tick(2);
      sda_m <= 1'b0;
      tick(LOW_CYC - 2);
      scl <= 1'b1;
      tick(HIGH_CYC);
      sda_m <= 1'b1;
      tick(LOW_CYC);
   endtask

   // msb first, ninth pulse left to the device when the byte is whole
   task automatic send_bits(input logic [7:0] b, input int n, output logic ack);
      logic g;
      for (int i = 7; i > 7 - n; i--)
         clock_bit(b[i], g);
      if (n == 8)
         clock_bit(1'b1, g);
      ack = ~g;
   endtask

   // ack every byte but the last, which is nacked
   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic g;
      for (int i = 7; i >= 0; i--)
      begin
         clock_bit(1'b1, g);
         b[i] = g;
      end
      clock_bit(last, g);
   endtask
endmodule // sir_master

// ===== verif/sensor_i2c_register_port_test.sv
module sensor_i2c_register_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   import sir_pkg::*;

   typedef byte_type sir_bq_type[$];

   logic     ref_clk = 1'b0;
   logic     resetn  = 1'b0;
   logic     scl, sda_m, sda_out, sda_oe, int_n, sda_wire;
   byte_type amb_hi  = 8'h00;
   byte_type amb_lo  = 8'h00;
   byte_type proximity_channel    = 8'h00;
   logic     amb_ev  = 1'b0;
   logic     proximity_channel_ev = 1'b0;
   byte_type flags, exp_flags;
   byte_type mirror [256];
   int       fails, total_checks, cycles;

   always #20 ref_clk = ~ref_clk;
   // pull-up on data, device and master both open-drain
   assign sda_wire = (sda_oe ? sda_out : 1'b1) & sda_m;

   sir_port u_dut
   (
      .ref_clk         (ref_clk),
      .resetn          (resetn),
      .scl_in          (scl),
      .sda_in          (sda_wire),
      .sda_out         (sda_out),
      .sda_oe          (sda_oe),
      .ambient_high    (amb_hi),
      .ambient_low     (amb_lo),
      .proximity_value (proximity_channel),
      .ambient_event   (amb_ev),
      .proximity_event (proximity_channel_ev),
      .interrupt_flags (flags),
      .int_n           (int_n)
   );

   sir_master u_master
   (
      .ref_clk  (ref_clk),
      .scl      (scl),
      .sda_m    (sda_m),
      .sda_wire (sda_wire)
   );

   task automatic final_report();
      $display("checks %0d failures %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check_byte(input byte_type got, input byte_type exp);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
      end
   endtask

   // what a read stream from p should return
   function automatic sir_bq_type exp_seq(input int p, input int n);
      sir_bq_type q;
      for (int i = 0; i < n; i++)
      begin
         q.push_back(p == 0 ? exp_flags : p == 4 ? amb_hi : p == 5 ? amb_lo :
                     p == 'h15 ? proximity_channel : p >= ADDR_RSVD ? ZERO_BYTE : mirror[p]);
         p = (p == ADDR_TOP) ? p : p + 1;
      end
      return q;
   endfunction

   task automatic wr_regs(input int ptr, input sir_bq_type d);
      logic a;
      u_master.start();
      u_master.send_bits({DEV_ADDR, 1'b0}, 8, a);
      check_bit(a, 1'b1);
      u_master.send_bits(8'(ptr), 8, a);
      check_bit(a, 1'b1);
      foreach (d[i])
      begin
         u_master.send_bits(d[i], 8, a);
         check_bit(a, 1'b1);
         if (!(ptr inside {0, 4, 5, 'h15}) && ptr < ADDR_RSVD)
            mirror[ptr] = d[i];
         ptr++;
      end
      u_master.stop();
   endtask

   // ptr below zero: plain start, pointer goes back to zero
   task automatic rd_check(input int ptr, input sir_bq_type exp);
      logic     a;
      byte_type b;
      u_master.start();
      if (ptr >= 0)
      begin
         u_master.send_bits({DEV_ADDR, 1'b0}, 8, a);
         check_bit(a, 1'b1);
         u_master.send_bits(8'(ptr), 8, a);
         check_bit(a, 1'b1);
         u_master.start();
      end
      u_master.send_bits({DEV_ADDR, 1'b1}, 8, a);
      check_bit(a, 1'b1);
      foreach (exp[i])
      begin
         u_master.recv_byte(i == exp.size() - 1, b);
         check_byte(b, exp[i]);
      end
      u_master.stop();
   endtask

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         $display("[FAIL] %0t run did not finish", $time);
         final_report();
      end
   end

   initial
   begin
      sir_bq_type q;
      logic       a;
      void'($urandom(32'h6dd4b5b8));
      foreach (mirror[i])
         mirror[i] = CFG_RESET;
      exp_flags = FLAGS_RESET;
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check_byte(flags, FLAGS_RESET);
      check_bit(int_n, 1'b1);
      u_master.start();
      u_master.send_bits({DEV_ADDR ^ 7'($urandom_range(1, 127)), 1'b0}, 8, a);
      check_bit(a, 1'b0);
      u_master.stop();
      rd_check(-1, exp_seq(0, 2));
      exp_flags = ZERO_BYTE;
      check_byte(flags, ZERO_BYTE);
      for (int i = 6; i <= 'h0c; i++)
         q.push_back(i == 'h0a ? ZERO_BYTE : 8'($urandom));
      wr_regs(6, q);
      q = {8'hf0, 8'($urandom)};
      wr_regs(2, q);
      q = {8'h13};
      wr_regs(1, q);
      rd_check(1, exp_seq(1, 3));
      rd_check(6, exp_seq(6, 7));
      // stop halfway through a data byte leaves the register alone
      u_master.start();
      u_master.send_bits({DEV_ADDR, 1'b0}, 8, a);
      check_bit(a, 1'b1);
      u_master.send_bits(ADDR_RXCFG, 8, a);
      check_bit(a, 1'b1);
      u_master.send_bits(8'($urandom), 4, a);
      u_master.stop();
      rd_check(2, exp_seq(2, 2));
      @(posedge ref_clk);
      amb_hi <= 8'($urandom);
      amb_lo <= 8'($urandom);
      proximity_channel   <= 8'($urandom);
      amb_ev <= 1'b1;
      @(posedge ref_clk);
      amb_ev <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check_byte(flags, 8'h01);
      check_bit(int_n, 1'b0);
      exp_flags = 8'h01;
      rd_check(-1, exp_seq(0, 1));
      exp_flags = ZERO_BYTE;
      check_bit(int_n, 1'b1);
      rd_check(4, exp_seq(4, 2));
      proximity_channel_ev <= 1'b1;
      @(posedge ref_clk);
      proximity_channel_ev <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check_byte(flags, 8'h02);
      check_bit(int_n, 1'b0);
      rd_check('h15, exp_seq('h15, 1));
      q = {ZERO_BYTE};
      wr_regs(1, q);
      check_byte(flags, ZERO_BYTE);
      check_bit(int_n, 1'b1);
      // a pending flag makes a wrapped pointer visible: it would read and clear it
      amb_ev <= 1'b1;
      @(posedge ref_clk);
      amb_ev <= 1'b0;
      rd_check('hfe, exp_seq('hfe, 3));
      check_byte(flags, 8'h01);
      check_bit(int_n, 1'b1);
      // reset in mid-run: power-on flag returns and stays off the pin
      resetn <= 1'b0;
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check_byte(flags, FLAGS_RESET);
      check_bit(int_n, 1'b1);
      q = {8'h17};
      wr_regs(1, q);
      check_byte(flags, FLAGS_RESET);
      check_bit(int_n, 1'b1);
      final_report();
   end
endmodule // sensor_i2c_register_port_test
